// ### bench/ospt_checker.sv
// port assertions for the oscillator select block
`timescale 1ns/1ps
`include "ospt_defs.vh"
module ospt_checker (
    input wire pclk, // clock
    input wire presetn, // async reset, low
    input wire psel, // select
    input wire penable, // access phase
    input wire pwrite, // direction
    input wire [11:0] paddr, // address
    input wire [31:0] pwdata, // write data
    input wire [3:0] pstrb, // strobes
    input wire [31:0] prdata, // read data
    input wire pready, // done
    input wire pslverr, // error
    input wire [1:0] osc_src_sel, // source
    input wire internal_osc_en, // internal run
    input wire main_osc_en, // main run
    input wire [8:0] pll_mult, // multiplier
    input wire [4:0] pll_div, // divider
    input wire pll_code_valid // usable code
);
    wire done = psel && penable && pready; // completing edge
    wire wr_cfg = done && pwrite && paddr == `OSPT_RCC_ADDR; // config write
    wire rd_cfg = done && !pwrite && paddr == `OSPT_RCC_ADDR; // config read
    wire rd_rb = done && !pwrite && paddr == `OSPT_PLLRB_ADDR; // readback read
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_src_select: assert property (wr_cfg && pstrb[0] |=> osc_src_sel == $past(pwdata[5:4]))
        else $error("source select wrong");
    a_reset_state: assert property ($rose(presetn) |-> osc_src_sel == 2'h1 && !main_osc_en)
        else $error("reset state wrong");
    a_int_enable: assert property (wr_cfg && pstrb[0] |=> internal_osc_en == !$past(pwdata[1]))
        else $error("internal enable wrong");
    a_main_enable: assert property (wr_cfg && pstrb[0] |=> main_osc_en == !$past(pwdata[0]))
        else $error("main enable wrong");
    a_ratio_hold: assert property ($changed({pll_mult, pll_div}) |-> $past(wr_cfg, 2))
        else $error("ratio changed without write");
    a_rb_fields: assert property (rd_rb |-> prdata == {18'h0, pll_mult, pll_div})
        else $error("readback mismatch");
    a_cfg_rsv: assert property (rd_cfg |-> prdata[3:2] == 2'h0)
        else $error("reserved bits set");
    a_code_valid: assert property (pll_code_valid == (pll_mult != 9'h0))
        else $error("code valid wrong");
    a_ratio_next: assert property (wr_cfg && pstrb[1:0] == 2'h3 |-> ##2 pll_code_valid == ($past(pwdata[9:6], 2) >= 4'h4))
        else $error("translation not refreshed in time");
    c_write: cover property (wr_cfg);
    c_readback: cover property (rd_rb);
    c_ratio: cover property ($changed(pll_mult));
endmodule // ospt_checker

bind ospt_top ospt_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_src_sel(osc_src_sel), .internal_osc_en(internal_osc_en),
    .main_osc_en(main_osc_en), .pll_mult(pll_mult), .pll_div(pll_div), .pll_code_valid(pll_code_valid));

// ### bench/tb.sv
// self-checking bench for the oscillator select block
`timescale 1ns/1ps
`include "ospt_defs.vh"
module tb;
    logic pclk, presetn, psel, penable, pwrite; // master side
    logic [11:0] paddr; // address
    logic [31:0] pwdata, prdata, rd, cfg, lf, d; // data, model, random
    logic [3:0] pstrb; // strobes
    logic pready, pslverr, err; // answer
    logic [1:0] osc_src_sel; // source
    logic internal_osc_en, main_osc_en, pll_code_valid; // enables
    logic [8:0] pll_mult; // multiplier
    logic [4:0] pll_div; // divider
    int bad_count, total_checks; // counters
    ospt_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_src_sel(osc_src_sel), .internal_osc_en(internal_osc_en), .main_osc_en(main_osc_en),
        .pll_mult(pll_mult), .pll_div(pll_div), .pll_code_valid(pll_code_valid));
    // 40 MHz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // expected multiplier and divider for a crystal code
    function automatic logic [13:0] ratio(input logic [3:0] c);
        case (c)
            4'h4: ratio = {9'h1BF, 5'h03};
            4'h5: ratio = {9'h1B2, 5'h03};
            4'h6: ratio = {9'h190, 5'h03};
            4'h7: ratio = {9'h187, 5'h03};
            4'h8: ratio = {9'h197, 5'h04};
            4'h9: ratio = {9'h190, 5'h04};
            4'hA: ratio = {9'h187, 5'h04};
            4'hB: ratio = {9'h190, 5'h05};
            4'hC: ratio = {9'h187, 5'h05};
            4'hD: ratio = {9'h17C, 5'h06};
            4'hE: ratio = {9'h190, 5'h07};
            4'hF: ratio = {9'h187, 5'h07};
            default: ratio = 14'h0000; // unusable codes
        endcase
    endfunction
    // random source
    function automatic logic [31:0] nx(input logic [31:0] s);
        nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one apb transfer, waits for pready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            bad_count++;
            $display("BAD %0t no pready", $time);
            summarize;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // config write with byte merge into the model
    task automatic wcfg(input logic [31:0] wd, input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & 32'h000003F3;
        apb(1'b1, `OSPT_RCC_ADDR, wd, s);
        cfg = (cfg & ~m) | (wd & m);
    endtask
    // read every register and compare every output
    task automatic check_all;
        apb(1'b0, `OSPT_RCC_ADDR, 32'h0, 4'h0);
        chk(rd, cfg);
        apb(1'b0, `OSPT_PLLRB_ADDR, 32'h0, 4'h0);
        chk(rd, {18'h0, ratio(cfg[9:6])});
        chk({18'h0, pll_mult, pll_div}, {18'h0, ratio(cfg[9:6])});
        chk({31'h0, err}, 32'h0);
        chk({31'h0, pll_code_valid}, {31'h0, cfg[9:6] >= 4'h4});
        chk({30'h0, osc_src_sel}, {30'h0, cfg[5:4]});
        chk({31'h0, internal_osc_en}, {31'h0, !cfg[1]});
        chk({31'h0, main_osc_en}, {31'h0, !cfg[0]});
        apb(1'b0, `OSPT_STAT_ADDR, 32'h0, 4'h0);
        chk(rd, {28'h0, cfg[5:4], !cfg[1], !cfg[0]});
    endtask
    task automatic do_reset;
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        cfg = 32'h000002D1;
    endtask
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        bad_count = 0;
        total_checks = 0;
        lf = 32'h80E3787A;
        do_reset;
        check_all;
        for (int i = 0; i < 40; i++) begin
            lf = nx(lf);
            d = lf;
            if (i < 16) begin
                d[9:6] = i[3:0];
                d[5:4] = i[1:0];
            end
            wcfg(d, (i < 16) ? 4'hF : lf[31:28]);
            check_all;
        end
        apb(1'b1, 12'h100, 32'hFFFFFFFF, 4'hF);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h100, 32'h0, 4'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, `OSPT_PLLRB_ADDR, 32'h0, 4'hF);
        check_all;
        do_reset;
        check_all;
        summarize;
    end
endmodule // tb

// ### core/ospt_defs.vh
// register map, field layout, reset values and codes of the oscillator select block
`ifndef OSPT_DEFS_VH
`define OSPT_DEFS_VH

// byte addresses of the registers (low 12 bits of paddr)
`define OSPT_ADDR_W 12
`define OSPT_RCC_ADDR 12'h060
`define OSPT_PLLRB_ADDR 12'h064
`define OSPT_STAT_ADDR 12'h068

// run_clock_config field positions
`define OSPT_CRYSTAL_FREQ_CODE_MSB 9
`define OSPT_CRYSTAL_FREQ_CODE_LSB 6
`define OSPT_OSC_MSB 5
`define OSPT_OSC_LSB 4
`define OSPT_RSV_MSB 3
`define OSPT_RSV_LSB 2
`define OSPT_INTERNAL_OSC_DISABLE_BIT 1
`define OSPT_MAIN_OSC_DISABLE_BIT 0

// run_clock_config reset values
`define OSPT_CRYSTAL_FREQ_CODE_RST 4'hB
`define OSPT_OSC_RST 2'h1
`define OSPT_INTERNAL_OSC_DISABLE_RST 1'h0
`define OSPT_MAIN_OSC_DISABLE_RST 1'h1

// pll_ratio_readback field positions
`define OSPT_MULT_MSB 13
`define OSPT_MULT_LSB 5
`define OSPT_DIV_MSB 4
`define OSPT_DIV_LSB 0

// translation of the reset crystal code (6 MHz)
`define OSPT_MULT_RST 9'h190
`define OSPT_DIV_RST 5'h05

// clock status register bit positions
`define OSPT_ST_MAIN_BIT 0
`define OSPT_ST_INT_BIT 1
`define OSPT_ST_SRC_MSB 3
`define OSPT_ST_SRC_LSB 2

// oscillator source codes
`define OSPT_SRC_MAIN 2'h0
`define OSPT_SRC_INT 2'h1
`define OSPT_SRC_INT_DIV4 2'h2
`define OSPT_SRC_LOWF 2'h3

// lowest crystal code usable with the pll
`define OSPT_CRYSTAL_FREQ_CODE_MIN_PLL 4'h4

`endif

// ### core/ospt_top.v
// oscillator source select, oscillator enables and pll translation with apb access
`timescale 1ns/1ps
`include "ospt_defs.vh"

// What this block does
// - bits 5:4 choose the oscillator source
// - source resets to internal oscillator
// - internal oscillator runs unless bit 1 set
// - main oscillator off while bit 0 set
// - translation loads at reset, follows crystal changes
// - pll out is osc times mult over div+1
// - multiplier at bits 13:5, upper bits zero
// - divider at bits 4:0, matches pll input
// - config bits 3:2 always read zero
// - crystal code resets to 0xB, 0-3 unusable
module ospt_top (
    input wire pclk, // apb clock, 40 MHz
    input wire presetn, // async reset, active low
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction, high for write
    input wire [11:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    input wire [3:0] pstrb, // apb write byte strobes
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb transfer done
    output reg pslverr, // apb error, unmapped address
    output reg [1:0] osc_src_sel, // selected oscillator input
    output reg internal_osc_en, // internal oscillator run enable
    output reg main_osc_en, // main oscillator run enable
    output reg [8:0] pll_mult, // multiplier driven into the pll
    output reg [4:0] pll_div, // divider driven into the pll
    output reg pll_code_valid // crystal code usable with the pll
);

    // apb handshake states
    localparam ST_IDLE = 1'b0; // waiting for an access phase
    localparam ST_DONE = 1'b1; // pready high, transfer completes

    // bus state
    reg apb_state; // handshake state
    reg next_apb_state; // next handshake state

    // run_clock_config fields
    reg [3:0] crystal_freq_code; // crystal code field
    reg [1:0] osc_src_field; // oscillator source field
    reg internal_osc_disable; // internal oscillator disable bit
    reg main_osc_disable; // main oscillator disable bit
    reg [3:0] next_crystal_freq_code; // crystal field after this cycle
    reg [1:0] next_osc_src_field; // source field after this cycle
    reg next_internal_osc_disable; // internal disable after this cycle
    reg next_main_osc_disable; // main disable after this cycle

    // translation tracking
    reg [3:0] loaded_code; // crystal code the pll values belong to
    wire [8:0] lookup_mult; // multiplier from the lookup
    wire [4:0] lookup_div; // divider from the lookup
    wire code_changed; // crystal field differs from loaded code

    // bus decode
    wire access_cyc; // access phase present
    wire commit; // edge where the transfer takes effect
    wire hit_rcc; // address is run_clock_config
    wire hit_pllrb; // address is pll_ratio_readback
    wire hit_stat; // address is clock status
    wire mapped; // address is one of the registers
    wire [31:0] wmask; // per bit write enable from strobes
    wire [31:0] rcc_word; // run_clock_config as read
    wire [31:0] merged_wr; // config word after the write
    reg [31:0] read_word; // selected read value

    // combinational translation of the stored crystal code
    ospt_xlate u_xlate (
        .crystal_freq_code(crystal_freq_code),
        .pll_mult(lookup_mult),
        .pll_div(lookup_div)
    );

    // decode of the address and phase
    assign access_cyc = psel & penable;
    assign commit = access_cyc & (apb_state == ST_DONE);
    assign hit_rcc = (paddr == `OSPT_RCC_ADDR);
    assign hit_pllrb = (paddr == `OSPT_PLLRB_ADDR);
    assign hit_stat = (paddr == `OSPT_STAT_ADDR);
    assign mapped = hit_rcc | hit_pllrb | hit_stat;

    // expand byte strobes to bit enables
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_mask
            assign wmask[gi] = pstrb[gi / 8];
        end
    endgenerate

    // config word as software sees it, reserved bits zero
    assign rcc_word = {
        22'h0,
        crystal_freq_code,
        osc_src_field,
        2'h0,
        internal_osc_disable,
        main_osc_disable
    };

    // new word where strobes allow, old bits elsewhere
    assign merged_wr = (pwdata & wmask) | (rcc_word & ~wmask);

    // refresh needed when the crystal field moved
    assign code_changed = (crystal_freq_code != loaded_code);

    // apb handshake: one wait cycle, then pready
    always @* begin
        next_apb_state = apb_state;
        case (apb_state)
            ST_IDLE: begin
                if (access_cyc) begin
                    next_apb_state = ST_DONE; // answer next edge
                end
            end
            ST_DONE: begin
                next_apb_state = ST_IDLE; // transfer ends here
            end
            default: begin
                next_apb_state = ST_IDLE;
            end
        endcase
    end

    // read mux over the mapped registers
    always @* begin
        read_word = 32'h00000000;
        if (hit_rcc) begin
            read_word = rcc_word;
        end else if (hit_pllrb) begin
            // multiplier and divider as driven, upper bits zero
            read_word = {18'h0, pll_mult, pll_div};
        end else if (hit_stat) begin
            // live oscillator state
            read_word[`OSPT_ST_MAIN_BIT] = main_osc_en;
            read_word[`OSPT_ST_INT_BIT] = internal_osc_en;
            read_word[`OSPT_ST_SRC_MSB:`OSPT_ST_SRC_LSB] = osc_src_sel;
        end
    end

    // next values of the config fields
    always @* begin
        next_crystal_freq_code = crystal_freq_code;
        next_osc_src_field = osc_src_field;
        next_internal_osc_disable = internal_osc_disable;
        next_main_osc_disable = main_osc_disable;
        if (commit && pwrite && hit_rcc) begin
            // only config is writable, others ignore writes
            next_crystal_freq_code = merged_wr[`OSPT_CRYSTAL_FREQ_CODE_MSB:`OSPT_CRYSTAL_FREQ_CODE_LSB];
            next_osc_src_field = merged_wr[`OSPT_OSC_MSB:`OSPT_OSC_LSB];
            next_internal_osc_disable = merged_wr[`OSPT_INTERNAL_OSC_DISABLE_BIT];
            next_main_osc_disable = merged_wr[`OSPT_MAIN_OSC_DISABLE_BIT];
        end
    end

    // handshake and answer registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_state <= ST_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            apb_state <= next_apb_state;
            if (apb_state == ST_IDLE && access_cyc) begin
                // answer raised together with data and error
                pready <= 1'b1;
                pslverr <= ~mapped;
                prdata <= (pwrite || !mapped) ? 32'h00000000 : read_word;
            end else begin
                // one cycle answer, then back to idle
                pready <= 1'b0;
                pslverr <= 1'b0;
                prdata <= 32'h00000000;
            end
        end
    end

    // config field storage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crystal_freq_code <= `OSPT_CRYSTAL_FREQ_CODE_RST;
            osc_src_field <= `OSPT_OSC_RST;
            internal_osc_disable <= `OSPT_INTERNAL_OSC_DISABLE_RST;
            main_osc_disable <= `OSPT_MAIN_OSC_DISABLE_RST;
        end else begin
            crystal_freq_code <= next_crystal_freq_code;
            osc_src_field <= next_osc_src_field;
            internal_osc_disable <= next_internal_osc_disable;
            main_osc_disable <= next_main_osc_disable;
        end
    end

    // oscillator controls, same edge as the field write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_src_sel <= `OSPT_SRC_INT;
            internal_osc_en <= ~`OSPT_INTERNAL_OSC_DISABLE_RST;
            main_osc_en <= ~`OSPT_MAIN_OSC_DISABLE_RST;
        end else begin
            osc_src_sel <= next_osc_src_field;
            internal_osc_en <= ~next_internal_osc_disable;
            main_osc_en <= ~next_main_osc_disable;
        end
    end

    // pll translation, reset value is that of the reset crystal code
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_mult <= `OSPT_MULT_RST;
            pll_div <= `OSPT_DIV_RST;
            loaded_code <= `OSPT_CRYSTAL_FREQ_CODE_RST;
            pll_code_valid <= 1'b1;
        end else if (code_changed) begin
            // reload one edge after the crystal field write
            pll_mult <= lookup_mult;
            pll_div <= lookup_div;
            loaded_code <= crystal_freq_code;
            pll_code_valid <= (crystal_freq_code >= `OSPT_CRYSTAL_FREQ_CODE_MIN_PLL);
        end
    end

endmodule // ospt_top

// ### core/ospt_xlate.v
// crystal code to pll multiplier and divider lookup
`timescale 1ns/1ps
`include "ospt_defs.vh"

module ospt_xlate (
    input wire [3:0] crystal_freq_code, // crystal code from the config register
    output reg [8:0] pll_mult, // multiplier value for the pll
    output reg [4:0] pll_div // divider value for the pll, divides by value plus one
);

    // pll out = osc * mult / (div + 1), aimed near 400 MHz
    always @* begin
        case (crystal_freq_code)
            4'h4: begin
                pll_mult = 9'h1BF; // 3.579545 MHz
                pll_div = 5'h03;
            end
            4'h5: begin
                pll_mult = 9'h1B2; // 3.6864 MHz
                pll_div = 5'h03;
            end
            4'h6: begin
                pll_mult = 9'h190; // 4 MHz
                pll_div = 5'h03;
            end
            4'h7: begin
                pll_mult = 9'h187; // 4.096 MHz
                pll_div = 5'h03;
            end
            4'h8: begin
                pll_mult = 9'h197; // 4.9152 MHz
                pll_div = 5'h04;
            end
            4'h9: begin
                pll_mult = 9'h190; // 5 MHz
                pll_div = 5'h04;
            end
            4'hA: begin
                pll_mult = 9'h187; // 5.12 MHz
                pll_div = 5'h04;
            end
            4'hB: begin
                pll_mult = `OSPT_MULT_RST; // 6 MHz
                pll_div = `OSPT_DIV_RST;
            end
            4'hC: begin
                pll_mult = 9'h187; // 6.144 MHz
                pll_div = 5'h05;
            end
            4'hD: begin
                pll_mult = 9'h17C; // 7.3728 MHz
                pll_div = 5'h06;
            end
            4'hE: begin
                pll_mult = 9'h190; // 8 MHz
                pll_div = 5'h07;
            end
            4'hF: begin
                pll_mult = 9'h187; // 8.192 MHz
                pll_div = 5'h07;
            end
            default: begin
                pll_mult = 9'h000; // codes below 4: no pll setting
                pll_div = 5'h00;
            end
        endcase
    end

endmodule // ospt_xlate
